// ---- bench/uv_sensor_i2c_command_readout_tb_top.sv ----
// self-checking bench for the sensor core
`include "uvs_regs.svh"
`default_nettype none
module uv_sensor_i2c_command_readout_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 16;
  logic clock;
  logic srst;
  logic [11:0] uv_level;
  logic sda_oe;
  logic alert_oe;
  logic shutdown_select;
  logic refresh_stb;
  logic scl_pull;
  logic sda_pull;
  int fails;
  int compares;
  wire logic scl_line = !scl_pull;
  wire logic sda_line = !(sda_oe || sda_pull);
  wire logic alert_line = !alert_oe;
  uvs_sensor_top #(.HALF_CYCLES(HALF)) u_dut (.clock(clock), .srst(srst),
    .scl_i(scl_line), .sda_i(sda_line), .sda_o(), .sda_oe(sda_oe),
    .uv_level(uv_level), .alert_o(), .alert_oe(alert_oe),
    .shutdown_select(shutdown_select), .refresh_stb(refresh_stb));
  uvs_host_model u_host (.clock(clock), .sda(sda_line),
    .scl_pull(scl_pull), .sda_pull(sda_pull));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp,
    input string what);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr_cmd(input logic [7:0] cmd);
    logic [7:0] rd;
    logic nak;
    u_host.txn(`UVS_ADDR_CMD_WR, cmd, rd, nak);
    check(nak, 16'h0, "cmd ack");
  endtask
  task automatic rd_res(output logic [15:0] res);
    logic nak;
    u_host.txn(`UVS_ADDR_RES_LO_RD, 8'h00, res[7:0], nak);
    check(nak, 16'h0, "lo ack");
    u_host.txn(`UVS_ADDR_RES_HI_RD, 8'h00, res[15:8], nak);
    check(nak, 16'h0, "hi ack");
  endtask
  // gives 400 when no strobe shows up at all
  task automatic period(output int n);
    int k;
    for (k = 0; k < 400 && refresh_stb !== 1'b1; k++) @(negedge clock);
    @(negedge clock);
    for (n = 1; n < 400 && refresh_stb !== 1'b1; n++) @(negedge clock);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_scaling();
    logic [15:0] res;
    int n;
    uv_level = 12'h123;
    for (int it = 0; it < 4; it++)
    begin
      wr_cmd({4'h0, 2'(it), 2'h2});
      period(n);
      check(16'(n), 16'(HALF << it), "period");
      rd_res(res);
      check(res, 16'h0123 << it, "result");
    end
    $display("test_scaling done");
  endtask
  task automatic test_shutdown();
    logic [15:0] res;
    int n;
    wr_cmd(8'h03);
    check(shutdown_select, 16'h1, "sd set");
    uv_level = 12'h045;
    period(n);
    check(16'(n), 16'h0190, "no refresh");
    rd_res(res);
    check(res, 16'h0918, "held");
    wr_cmd(8'h02);
    period(n);
    check(16'(n), 16'(HALF), "wake period");
    rd_res(res);
    check(res, 16'h0045, "after wake");
    $display("test_shutdown done");
  endtask
  task automatic test_alert();
    logic [7:0] cmds [5] = '{8'h22, 8'h32, 8'h32, 8'h02, 8'h22};
    logic [11:0] lvls [5] = '{12'h070, 12'h070, 12'h0A0, 12'h0A0, 12'h050};
    logic [15:0] thr;
    int n;
    for (int i = 0; i < 5; i++)
    begin
      uv_level = lvls[i];
      wr_cmd(cmds[i]);
      period(n);
      repeat (3) @(negedge clock);
      thr = cmds[i][4] ? `UVS_THRESH_WIN1 : `UVS_THRESH_WIN0;
      check(!alert_line, cmds[i][5] && lvls[i] >= thr, "alert");
    end
    $display("test_alert done");
  endtask
  task automatic test_refused();
    logic [7:0] rd;
    logic nak;
    u_host.txn(8'h72, 8'hFF, rd, nak);
    check(nak, 16'h1, "reserved nak");
    u_host.txn(8'h75, 8'hFF, rd, nak);
    check(nak, 16'h1, "unknown nak");
    check(rd, 16'h00FF, "bus released");
    $display("test_refused done");
  endtask
  // reset in mid-run must leave the core active with a cleared result
  task automatic test_reset();
    logic [15:0] res;
    wr_cmd(8'h23);
    uv_level = 12'h000;
    check(shutdown_select, 16'h1, "sd before reset");
    @(negedge clock);
    srst = 1'b1;
    repeat (6) @(negedge clock);
    srst = 1'b0;
    repeat (3) @(negedge clock);
    check(shutdown_select, 16'h0, "sd after reset");
    check(alert_line, 16'h1, "alert after reset");
    rd_res(res);
    check(res, 16'h0000, "result after reset");
    $display("test_reset done");
  endtask
  // ----------------------------------------
  // clock, main sequence, watchdog
  // ----------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial
  begin
    fails = 0;
    compares = 0;
    srst = 1'b1;
    uv_level = 12'h000;
    repeat (6) @(negedge clock);
    srst = 1'b0;
    repeat (3) @(negedge clock);
    check(shutdown_select, 16'h0, "sd reset");
    check(alert_line, 16'h1, "alert idle");
    test_scaling();
    test_shutdown();
    test_alert();
    test_refused();
    test_reset();
    tally_and_finish();
  end
  initial
  begin
    repeat (40000) @(posedge clock);
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule // uv_sensor_i2c_command_readout_tb_top
`default_nettype wire

// ---- bench/uvs_host_model.sv ----
// two-wire host model for the sensor core
`default_nettype none
module uvs_host_model
(
  input wire logic clock,
  input wire logic sda,
  output logic scl_pull,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // bus cycles, ten clocks a half bit
  // ----------------------------------------
  initial
  begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  task automatic half_bit();
    repeat (10) @(negedge clock);
  endtask
  // a released line floats up through the pull-up
  task automatic bit_io(input logic tx, output logic rx);
    sda_pull = !tx;
    half_bit();
    scl_pull = 1'b0;
    half_bit();
    rx = sda;
    scl_pull = 1'b1;
  endtask
  // one byte at one address, no sub-address
  task automatic txn(input logic [7:0] addr, input logic [7:0] wd,
    output logic [7:0] rd, output logic nak);
    logic [7:0] tx;
    logic a;
    tx = addr[0] ? 8'hFF : wd;
    sda_pull = 1'b1;
    half_bit();
    scl_pull = 1'b1;
    for (int i = 7; i >= 0; i--) bit_io(addr[i], a);
    bit_io(1'b1, nak);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rd[i]);
    bit_io(1'b1, a);
    sda_pull = 1'b1;
    half_bit();
    scl_pull = 1'b0;
    half_bit();
    sda_pull = 1'b0;
    half_bit();
  endtask
endmodule // uvs_host_model
`default_nettype wire

// ---- bench/uvs_sensor_monitor.sv ----
// port-level checks on the sensor core
`default_nettype none
module uvs_sensor_monitor
#(
  parameter int HALF_CYCLES = 16
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic alert_o,
  input wire logic alert_oe,
  input wire logic shutdown_select,
  input wire logic refresh_stb
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // cycles since the last refresh
  // ----------------------------------------
  int gap_r;
  int gap_nxt;
  always_comb
  begin
    gap_nxt = refresh_stb ? 0 : gap_r + 1;
  end
  always_ff @(posedge clock)
  begin
    gap_r <= srst ? 0 : gap_nxt;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_sda_low; sda_o == 1'b0; endproperty
  a_sda_low: assert property (p_sda_low)
    else $error("data pin driven high");
  property p_alert_low; alert_o == 1'b0; endproperty
  a_alert_low: assert property (p_alert_low)
    else $error("alert pin driven high");
  property p_stb_pulse; refresh_stb |=> !refresh_stb; endproperty
  a_stb_pulse: assert property (p_stb_pulse)
    else $error("refresh strobe longer than one cycle");
  // slack of two covers where the counter and strobe phases meet
  property p_min_gap; refresh_stb |-> gap_r >= HALF_CYCLES - 2; endproperty
  a_min_gap: assert property (p_min_gap)
    else $error("refresh faster than half period");
  property p_sd_quiet; shutdown_select ##1 shutdown_select |-> !refresh_stb;
  endproperty
  a_sd_quiet: assert property (p_sd_quiet)
    else $error("refresh while shut down");
  property p_sda_edge; $changed(sda_oe) |-> !scl_i; endproperty
  a_sda_edge: assert property (p_sda_edge)
    else $error("data changed while bus clock high");
  property p_cmd_ack; $changed(shutdown_select) |-> !scl_i ##[0:4] sda_oe;
  endproperty
  a_cmd_ack: assert property (p_cmd_ack)
    else $error("command change outside a write ack");
  property p_alert_cause;
    $changed(alert_oe) |-> !scl_i || $past(refresh_stb)
      || $past(refresh_stb, 2);
  endproperty
  a_alert_cause: assert property (p_alert_cause)
    else $error("alert moved without refresh or command");
  c_refresh: cover property (refresh_stb);
  c_alert: cover property ($rose(alert_oe));
  c_sleep: cover property ($rose(shutdown_select));
endmodule // uvs_sensor_monitor

bind uvs_sensor_top uvs_sensor_monitor #(.HALF_CYCLES(HALF_CYCLES)) u_mon (
  .clock(clock), .srst(srst), .scl_i(scl_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .alert_o(alert_o), .alert_oe(alert_oe),
  .shutdown_select(shutdown_select), .refresh_stb(refresh_stb));
`default_nettype wire

// ---- include/uvs_pkg.sv ----
// types shared by the sensor readout design
`default_nettype none

package uvs_pkg;

  // ----------------------------------------
  // serial slave states, gray along the usual path
  // ----------------------------------------
  typedef enum logic [2:0] {
    UVS_IDLE  = 3'h0,
    UVS_ADDR  = 3'h1,
    UVS_AACK  = 3'h3,
    UVS_WDATA = 3'h2,
    UVS_WACK  = 3'h6,
    UVS_RDATA = 3'h7,
    UVS_RACK  = 3'h5
  } uvs_bus_state_type;

  typedef enum logic [1:0] {
    UVS_IT_HALF = 2'h0,
    UVS_IT_ONE  = 2'h1,
    UVS_IT_TWO  = 2'h2,
    UVS_IT_FOUR = 2'h3
  } uvs_it_type;

endpackage : uvs_pkg

`default_nettype wire

// ---- include/uvs_regs.svh ----
// register offsets, command fields, reset values and timing counts
`ifndef UVS_REGS_SVH
`define UVS_REGS_SVH

// ----------------------------------------
// bus address bytes (address plus direction bit)
// ----------------------------------------
`define UVS_ADDR_CMD_WR 8'h70
`define UVS_ADDR_RES_LO_RD 8'h71
`define UVS_ADDR_RES_HI_RD 8'h73

// ----------------------------------------
// command byte fields
// ----------------------------------------
`define UVS_CMD_SD_BIT 0
`define UVS_CMD_ONE_BIT 1
`define UVS_CMD_IT_LO 2
`define UVS_CMD_IT_HI 3
`define UVS_CMD_THD_BIT 4
`define UVS_CMD_ACK_BIT 5
`define UVS_CMD_RST 8'h02

// ----------------------------------------
// timing: half of the base period, in microseconds
// ----------------------------------------
`define UVS_CLK_MHZ 50
`define UVS_HALF_PERIOD_US 62500
`define UVS_HALF_PERIOD_CYC (`UVS_HALF_PERIOD_US * `UVS_CLK_MHZ)

// ----------------------------------------
// alert threshold windows, in result counts
// ----------------------------------------
`define UVS_THRESH_WIN0 16'h0066
`define UVS_THRESH_WIN1 16'h0091

`endif

// ---- src/uvs_i2c_slave.sv ----
// two-wire serial slave: one command byte in, one result byte out
`include "uvs_regs.svh"
`default_nettype none

module uvs_i2c_slave
(
  input wire logic clock,
  input wire logic srst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe,
  output logic cmd_stb,
  output logic [7:0] cmd_data,
  input wire logic [7:0] res_lo,
  input wire logic [7:0] res_hi
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic scl_d_r;
  logic sda_d_r;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_sync_r <= {scl_sync_r[0], scl_i};
      sda_sync_r <= {sda_sync_r[0], sda_i};
      scl_d_r <= scl_sync_r[1];
      sda_d_r <= sda_sync_r[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  assign scl_s = scl_sync_r[1];
  assign sda_s = sda_sync_r[1];
  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  assign start_c = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_c = scl_s && scl_d_r && !sda_d_r && sda_s;

  // ----------------------------------------
  // byte engine
  // ----------------------------------------
  uvs_pkg::uvs_bus_state_type st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sr_r, sr_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic hi_r, hi_nxt;
  logic nack_r, nack_nxt;
  logic oe_r, oe_nxt;
  logic stb_r, stb_nxt;

  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sr_nxt = sr_r;
    tx_nxt = tx_r;
    hi_nxt = hi_r;
    nack_nxt = nack_r;
    oe_nxt = oe_r;
    stb_nxt = 1'b0;
    if (start_c)
    begin
      st_nxt = uvs_pkg::UVS_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end
    else if (stop_c)
    begin
      st_nxt = uvs_pkg::UVS_IDLE;
      oe_nxt = 1'b0;
    end
    else
    begin
      case (st_r)
        uvs_pkg::UVS_IDLE:
        begin
          oe_nxt = 1'b0;
        end
        uvs_pkg::UVS_ADDR, uvs_pkg::UVS_WDATA:
        begin
          if (scl_rise)
          begin
            sr_nxt = {sr_r[6:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end
          else if (scl_fall && cnt_r == 4'h8)
          begin
            if (st_r == uvs_pkg::UVS_WDATA)
            begin
              stb_nxt = 1'b1;
              oe_nxt = 1'b1;
              st_nxt = uvs_pkg::UVS_WACK;
            end
            // reserved 0x72 and foreign addresses get no acknowledge
            else if (sr_r == `UVS_ADDR_CMD_WR ||
                     sr_r == `UVS_ADDR_RES_LO_RD ||
                     sr_r == `UVS_ADDR_RES_HI_RD)
            begin
              hi_nxt = (sr_r == `UVS_ADDR_RES_HI_RD);
              oe_nxt = 1'b1;
              st_nxt = uvs_pkg::UVS_AACK;
            end
            else
            begin
              st_nxt = uvs_pkg::UVS_IDLE;
            end
          end
        end
        uvs_pkg::UVS_AACK, uvs_pkg::UVS_RACK:
        begin
          if (scl_rise && st_r == uvs_pkg::UVS_RACK)
          begin
            nack_nxt = sda_s;
          end
          else if (scl_fall)
          begin
            cnt_nxt = 4'h0;
            if (st_r == uvs_pkg::UVS_AACK && !sr_r[0])
            begin
              oe_nxt = 1'b0;
              st_nxt = uvs_pkg::UVS_WDATA;
            end
            else if (st_r == uvs_pkg::UVS_RACK && nack_r)
            begin
              oe_nxt = 1'b0;
              st_nxt = uvs_pkg::UVS_IDLE;
            end
            else
            begin
              tx_nxt = hi_r ? res_hi : res_lo;
              oe_nxt = hi_r ? !res_hi[7] : !res_lo[7];
              st_nxt = uvs_pkg::UVS_RDATA;
            end
          end
        end
        uvs_pkg::UVS_WACK:
        begin
          if (scl_fall)
          begin
            oe_nxt = 1'b0;
            cnt_nxt = 4'h0;
            st_nxt = uvs_pkg::UVS_WDATA;
          end
        end
        uvs_pkg::UVS_RDATA:
        begin
          if (scl_rise)
          begin
            cnt_nxt = cnt_r + 4'h1;
          end
          else if (scl_fall)
          begin
            if (cnt_r == 4'h8)
            begin
              oe_nxt = 1'b0;
              st_nxt = uvs_pkg::UVS_RACK;
            end
            else
            begin
              tx_nxt = {tx_r[6:0], 1'b0};
              oe_nxt = !tx_r[6];
            end
          end
        end
        default:
        begin
          st_nxt = uvs_pkg::UVS_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      st_r <= uvs_pkg::UVS_IDLE;
      cnt_r <= 4'h0;
      sr_r <= 8'h00;
      tx_r <= 8'h00;
      hi_r <= 1'b0;
      nack_r <= 1'b0;
      oe_r <= 1'b0;
      stb_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sr_r <= sr_nxt;
      tx_r <= tx_nxt;
      hi_r <= hi_nxt;
      nack_r <= nack_nxt;
      oe_r <= oe_nxt;
      stb_r <= stb_nxt;
    end
  end

  assign sda_oe = oe_r;
  assign cmd_stb = stb_r;
  assign cmd_data = sr_r;

endmodule // uvs_i2c_slave

`default_nettype wire

// ---- src/uvs_sensor_top.sv ----
// ultraviolet sensor digital core: command, integration, result, alert
`include "uvs_regs.svh"
`default_nettype none

module uvs_sensor_top
#(
  parameter int HALF_CYCLES = `UVS_HALF_PERIOD_CYC,
  parameter int LEVEL_W = 12,
  parameter logic [15:0] THRESH_WIN0 = `UVS_THRESH_WIN0,
  parameter logic [15:0] THRESH_WIN1 = `UVS_THRESH_WIN1
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [LEVEL_W-1:0] uv_level,
  output logic alert_o,
  output logic alert_oe,
  output logic shutdown_select,
  output logic refresh_stb
);

  localparam int DIV_W = $clog2(HALF_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_CYCLES - 1);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // number of half-period ticks in one integration
  function automatic logic [3:0] it_len(input logic [1:0] sel);
    case (sel)
      uvs_pkg::UVS_IT_HALF: it_len = 4'h1;
      uvs_pkg::UVS_IT_ONE: it_len = 4'h2;
      uvs_pkg::UVS_IT_TWO: it_len = 4'h4;
      default: it_len = 4'h8;
    endcase
  endfunction

  // ----------------------------------------
  // serial slave
  // ----------------------------------------
  logic cmd_stb;
  logic [7:0] cmd_data;
  logic slv_oe;
  logic [15:0] result_r, result_nxt;

  uvs_i2c_slave u_slave (
    .clock(clock),
    .srst(srst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_oe(slv_oe),
    .cmd_stb(cmd_stb),
    .cmd_data(cmd_data),
    .res_lo(result_r[7:0]),
    .res_hi(result_r[15:8])
  );

  // ----------------------------------------
  // command byte
  // ----------------------------------------
  // bits 1, 6 and 7 are not stored; the host keeps them fixed
  logic sd_r, sd_nxt;
  logic [1:0] it_r, it_nxt;
  logic thd_r, thd_nxt;
  logic ack_en_r, ack_en_nxt;
  logic restart;

  always_comb
  begin
    sd_nxt = sd_r;
    it_nxt = it_r;
    thd_nxt = thd_r;
    ack_en_nxt = ack_en_r;
    restart = 1'b0;
    if (cmd_stb)
    begin
      sd_nxt = cmd_data[`UVS_CMD_SD_BIT];
      it_nxt = cmd_data[`UVS_CMD_IT_HI:`UVS_CMD_IT_LO];
      thd_nxt = cmd_data[`UVS_CMD_THD_BIT];
      ack_en_nxt = cmd_data[`UVS_CMD_ACK_BIT];
      restart = (it_nxt != it_r) || (sd_r && !sd_nxt);
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      sd_r <= 1'(`UVS_CMD_RST >> `UVS_CMD_SD_BIT);
      it_r <= 2'(`UVS_CMD_RST >> `UVS_CMD_IT_LO);
      thd_r <= 1'(`UVS_CMD_RST >> `UVS_CMD_THD_BIT);
      ack_en_r <= 1'(`UVS_CMD_RST >> `UVS_CMD_ACK_BIT);
    end
    else
    begin
      sd_r <= sd_nxt;
      it_r <= it_nxt;
      thd_r <= thd_nxt;
      ack_en_r <= ack_en_nxt;
    end
  end

  // ----------------------------------------
  // light level input
  // ----------------------------------------
  // level comes from the analog side; it moves slowly, so a plain
  // two-stage sync is accepted at the cost of a rare mixed sample
  logic [LEVEL_W-1:0] lvl_s1_r;
  logic [LEVEL_W-1:0] lvl_s2_r;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      lvl_s1_r <= '0;
      lvl_s2_r <= '0;
    end
    else
    begin
      lvl_s1_r <= uv_level;
      lvl_s2_r <= lvl_s1_r;
    end
  end

  // ----------------------------------------
  // integration and refresh
  // ----------------------------------------
  logic [DIV_W-1:0] div_r, div_nxt;
  logic [3:0] tick_r, tick_nxt;
  logic [15:0] acc_r, acc_nxt;
  logic refresh_r, refresh_nxt;
  logic [16:0] sum;
  logic half_tick;

  assign half_tick = (div_r == DIV_LAST);
  assign sum = {1'b0, acc_r} + 17'(lvl_s2_r);

  always_comb
  begin
    div_nxt = div_r;
    tick_nxt = tick_r;
    acc_nxt = acc_r;
    result_nxt = result_r;
    refresh_nxt = 1'b0;
    if (restart || sd_nxt)
    begin
      div_nxt = '0;
      tick_nxt = 4'h0;
      acc_nxt = 16'h0000;
    end
    else if (half_tick)
    begin
      div_nxt = '0;
      // one level sample per half period keeps counts linear
      acc_nxt = sum[16] ? 16'hFFFF : sum[15:0];
      if (tick_r + 4'h1 == it_len(it_r))
      begin
        tick_nxt = 4'h0;
        result_nxt = acc_nxt;
        acc_nxt = 16'h0000;
        refresh_nxt = 1'b1;
      end
      else
      begin
        tick_nxt = tick_r + 4'h1;
      end
    end
    else
    begin
      div_nxt = div_r + DIV_W'(1);
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      div_r <= '0;
      tick_r <= 4'h0;
      acc_r <= 16'h0000;
      result_r <= 16'h0000;
      refresh_r <= 1'b0;
    end
    else
    begin
      div_r <= div_nxt;
      tick_r <= tick_nxt;
      acc_r <= acc_nxt;
      result_r <= result_nxt;
      refresh_r <= refresh_nxt;
    end
  end

  // ----------------------------------------
  // alert line
  // ----------------------------------------
  logic alert_oe_r, alert_oe_nxt;
  logic [15:0] thresh;

  assign thresh = thd_r ? THRESH_WIN1 : THRESH_WIN0;

  always_comb
  begin
    alert_oe_nxt = ack_en_r && (result_r >= thresh);
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      alert_oe_r <= 1'b0;
    end
    else
    begin
      alert_oe_r <= alert_oe_nxt;
    end
  end

  // ----------------------------------------
  // pin outputs
  // ----------------------------------------
  // open-drain lines only ever drive low
  logic low_r;

  always_ff @(posedge clock)
  begin
    low_r <= 1'b0;
  end

  assign sda_o = low_r;
  assign sda_oe = slv_oe;
  assign alert_o = low_r;
  assign alert_oe = alert_oe_r;
  assign shutdown_select = sd_r;
  assign refresh_stb = refresh_r;

endmodule // uvs_sensor_top

`default_nettype wire
